// ### core/laatm_defs.svh
`ifndef LAATM_DEFS_SVH
`define LAATM_DEFS_SVH

// APB register byte addresses
`define LAATM_ADDR_STATUS_REG0 12'h000
`define LAATM_ADDR_STATUS_REG1 12'h004
`define LAATM_ADDR_INT_STATUS_REG0 12'h008
`define LAATM_ADDR_INT_STATUS_REG1 12'h00c
`define LAATM_ADDR_INT_EDGE_SEL_REG 12'h010
`define LAATM_ADDR_INT_MASK_REG0 12'h014
`define LAATM_ADDR_INT_MASK_REG1 12'h018
`define LAATM_ADDR_LOSC 12'h01c
`define LAATM_ADDR_AUTO_AIS_CTRL 12'h020
`define LAATM_ADDR_TX_CONFIG0 12'h024
`define LAATM_ADDR_MODE 12'h028

// Field positions
`define LAATM_B_LINE_SIGNAL_LOSS 0
`define LAATM_B_SYSTEM_SIGNAL_LOSS 1
`define LAATM_B_TX_LINE_SIGNAL_LOSS 2
`define LAATM_B_RXAIS 6
`define LAATM_B_TXAIS 7
`define LAATM_B_LOS_IES 1
`define LAATM_B_TX_LOSS_EDGE_SEL 2
`define LAATM_B_AIS_EDGE_SEL 6
`define LAATM_B_CRIT 7
`define LAATM_B_OE 6
`define LAATM_B_TXA_LINE_SIGNAL_LOSS 0
`define LAATM_B_TXA_SYSTEM_SIGNAL_LOSS 1
`define LAATM_B_RXA_LINE_SIGNAL_LOSS 2
`define LAATM_B_RXA_SYSTEM_SIGNAL_LOSS 3
`define LAATM_B_MODE_E1 0
`define LAATM_F_PERIOD 1:0
`define LAATM_F_AMP 3:2

// Reset values
`define LAATM_RST_BYTE 8'h00
`define LAATM_RST_TX_CONFIG0 8'h40

// AIS windows and zero thresholds
`define LAATM_E1_BLOCK 13'h01ff
`define LAATM_T1_BLOCK 13'h1fff
`define LAATM_E1_ZEROS 4'h3
`define LAATM_T1_ZEROS 4'h9

// Transmit loss periods in line bits, by period select
`define LAATM_TX_LINE_SIGNAL_LOSS_P0 12'h020
`define LAATM_TX_LINE_SIGNAL_LOSS_P1 12'h080
`define LAATM_TX_LINE_SIGNAL_LOSS_P2 12'h200
`define LAATM_TX_LINE_SIGNAL_LOSS_P3 12'h800

`endif

// ### core/laatm_monitor.sv
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "laatm_defs.svh"

module laatm_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic line_signal_loss,
  input wire logic system_signal_loss,
  input wire logic tx_line_pulse,
  input wire logic tx_line_low,
  input wire logic rx_bit_en,
  input wire logic rx_bit,
  input wire logic tx_bit_en,
  input wire logic tx_bit,
  input wire logic local_ref_clock,
  input wire logic rx_clock_in,
  input wire logic rx_data_in,
  input wire logic rx_data_pos_in,
  input wire logic rx_data_neg_in,
  input wire logic tx_data_pos_in,
  input wire logic tx_data_neg_in,
  input wire logic rx_pattern_on,
  input wire logic tx_pattern_on,
  input wire logic rx_pattern_bit,
  input wire logic tx_pattern_bit,
  input wire logic [1:0] tx_mf_sel,
  input wire logic [1:0] rx_mf_sel,
  output logic rx_data_out,
  output logic rx_data_pos_out,
  output logic rx_data_neg_out,
  output logic rx_clock_out,
  output logic tx_line_tip,
  output logic tx_line_ring,
  output logic tx_line_oe_n,
  output logic [1:0] tx_loss_amplitude_sel,
  output logic tx_multifunc_pin,
  output logic rx_multifunc_pin,
  output logic tx_loss_event,
  output logic rx_ais_event,
  output logic tx_ais_event,
  output logic int_n
);

  logic [7:0] status_reg0;
  logic [7:0] status_reg1;
  logic [7:0] int_status_reg0;
  logic [7:0] int_status_reg1;
  logic [7:0] int_edge_sel_reg;
  logic [7:0] int_mask_reg0;
  logic [7:0] int_mask_reg1;
  logic [7:0] loss_cfg;
  logic [7:0] auto_ais_ctrl;
  logic [7:0] tx_config0;
  logic [7:0] mode_cfg;
  logic [7:0] prev_status_reg0;
  logic [7:0] prev_status_reg1;
  logic [11:0] low_cnt;
  logic tx_line_signal_loss;
  logic [1:0] tx_loss_period_sel;
  logic alarm_criteria_sel;
  logic e1_mode;
  logic wr_en;
  logic rd_en;
  logic [1:0] ais_det;
  logic [1:0] bit_en;
  logic [1:0] bit_val;
  logic rx_ais_gen;
  logic tx_ais_gen;
  logic [7:0] next_int_status_reg0;
  logic [7:0] next_int_status_reg1;

  assign tx_loss_period_sel = loss_cfg[`LAATM_F_PERIOD];
  assign tx_loss_amplitude_sel = loss_cfg[`LAATM_F_AMP];
  assign alarm_criteria_sel = loss_cfg[`LAATM_B_CRIT];
  assign e1_mode = mode_cfg[`LAATM_B_MODE_E1];

  // Edge-selected event: rise only, or any change
  function automatic logic edge_hit(input logic cur, input logic prev, input logic any);
    edge_hit = any ? (cur ^ prev) : (cur & ~prev);
  endfunction

  function automatic logic [11:0] loss_period(input logic [1:0] sel);
    unique case (sel)
      2'h0: loss_period = `LAATM_TX_LINE_SIGNAL_LOSS_P0;
      2'h1: loss_period = `LAATM_TX_LINE_SIGNAL_LOSS_P1;
      2'h2: loss_period = `LAATM_TX_LINE_SIGNAL_LOSS_P2;
      2'h3: loss_period = `LAATM_TX_LINE_SIGNAL_LOSS_P3;
    endcase
  endfunction

  // APB slave, zero wait states
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_edge_sel_reg <= `LAATM_RST_BYTE;
      int_mask_reg0 <= `LAATM_RST_BYTE;
      int_mask_reg1 <= `LAATM_RST_BYTE;
      loss_cfg <= `LAATM_RST_BYTE;
      auto_ais_ctrl <= `LAATM_RST_BYTE;
      tx_config0 <= `LAATM_RST_TX_CONFIG0;
      mode_cfg <= `LAATM_RST_BYTE;
    end else if (wr_en) begin
      unique case (paddr)
        `LAATM_ADDR_INT_EDGE_SEL_REG: int_edge_sel_reg <= pwdata[7:0];
        `LAATM_ADDR_INT_MASK_REG0: int_mask_reg0 <= pwdata[7:0];
        `LAATM_ADDR_INT_MASK_REG1: int_mask_reg1 <= pwdata[7:0];
        `LAATM_ADDR_LOSC: loss_cfg <= pwdata[7:0];
        `LAATM_ADDR_AUTO_AIS_CTRL: auto_ais_ctrl <= pwdata[7:0];
        `LAATM_ADDR_TX_CONFIG0: tx_config0 <= pwdata[7:0];
        `LAATM_ADDR_MODE: mode_cfg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (paddr)
        `LAATM_ADDR_STATUS_REG0: prdata <= {24'h000000, status_reg0};
        `LAATM_ADDR_STATUS_REG1: prdata <= {24'h000000, status_reg1};
        `LAATM_ADDR_INT_STATUS_REG0: prdata <= {24'h000000, int_status_reg0};
        `LAATM_ADDR_INT_STATUS_REG1: prdata <= {24'h000000, int_status_reg1};
        `LAATM_ADDR_INT_EDGE_SEL_REG: prdata <= {24'h000000, int_edge_sel_reg};
        `LAATM_ADDR_INT_MASK_REG0: prdata <= {24'h000000, int_mask_reg0};
        `LAATM_ADDR_INT_MASK_REG1: prdata <= {24'h000000, int_mask_reg1};
        `LAATM_ADDR_LOSC: prdata <= {24'h000000, loss_cfg};
        `LAATM_ADDR_AUTO_AIS_CTRL: prdata <= {24'h000000, auto_ais_ctrl};
        `LAATM_ADDR_TX_CONFIG0: prdata <= {24'h000000, tx_config0};
        `LAATM_ADDR_MODE: prdata <= {24'h000000, mode_cfg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Transmit loss detector, counted per transmit line bit
  // A floating own output with a floating partner gives no pulses, so both report loss
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt <= 12'h000;
      tx_line_signal_loss <= 1'b0;
    end else if (tx_line_pulse) begin
      low_cnt <= 12'h000;
      tx_line_signal_loss <= 1'b0;
    end else if (tx_bit_en && tx_line_low) begin
      if (low_cnt >= loss_period(tx_loss_period_sel) - 12'h001) begin
        tx_line_signal_loss <= 1'b1;
      end else begin
        low_cnt <= low_cnt + 12'h001;
      end
    end
  end

  // AIS detection per path
  assign bit_en = {tx_bit_en, rx_bit_en};
  assign bit_val = {tx_bit, rx_bit};

  generate
    for (genvar p = 0; p < 2; p++) begin : g_ais
      logic [12:0] bit_cnt;
      logic [3:0] zero_cnt;
      logic prev_low;
      logic prev_high;
      laatm_pkg::laatm_ais_state_t state;
      logic blk_end;
      logic [3:0] zeros_now;
      logic low;
      logic [3:0] thr;
      assign thr = e1_mode ? `LAATM_E1_ZEROS : `LAATM_T1_ZEROS;
      assign blk_end = bit_cnt == (e1_mode ? `LAATM_E1_BLOCK : `LAATM_T1_BLOCK);
      assign zeros_now = zero_cnt + {3'h0, ~bit_val[p] & (zero_cnt != 4'hf)};
      assign low = zeros_now < thr;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          bit_cnt <= 13'h0000;
          zero_cnt <= 4'h0;
          prev_low <= 1'b0;
          prev_high <= 1'b0;
          state <= laatm_pkg::LAATM_AIS_CLEAR;
        end else if (bit_en[p]) begin
          if (blk_end) begin
            bit_cnt <= 13'h0000;
            zero_cnt <= 4'h0;
            prev_low <= low;
            prev_high <= ~low;
            unique case (state)
              laatm_pkg::LAATM_AIS_CLEAR:
                if (low && (!e1_mode || alarm_criteria_sel || prev_low)) begin
                  state <= laatm_pkg::LAATM_AIS_SET;
                end
              laatm_pkg::LAATM_AIS_SET:
                if (!low && (!e1_mode || alarm_criteria_sel || prev_high)) begin
                  state <= laatm_pkg::LAATM_AIS_CLEAR;
                end
            endcase
          end else begin
            bit_cnt <= bit_cnt + 13'h0001;
            zero_cnt <= zeros_now;
          end
        end
      end
      assign ais_det[p] = state == laatm_pkg::LAATM_AIS_SET;
    end
  endgenerate

  // Status registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_reg0 <= `LAATM_RST_BYTE;
      status_reg1 <= `LAATM_RST_BYTE;
      prev_status_reg0 <= `LAATM_RST_BYTE;
      prev_status_reg1 <= `LAATM_RST_BYTE;
    end else begin
      status_reg0 <= 8'h00;
      status_reg0[`LAATM_B_LINE_SIGNAL_LOSS] <= line_signal_loss;
      status_reg0[`LAATM_B_SYSTEM_SIGNAL_LOSS] <= system_signal_loss;
      status_reg0[`LAATM_B_TX_LINE_SIGNAL_LOSS] <= tx_line_signal_loss;
      status_reg1 <= 8'h00;
      status_reg1[`LAATM_B_RXAIS] <= ais_det[0];
      status_reg1[`LAATM_B_TXAIS] <= ais_det[1];
      prev_status_reg0 <= status_reg0;
      prev_status_reg1 <= status_reg1;
    end
  end

  // Sticky interrupt bits; a new event beats a write-one clear
  always_comb begin
    next_int_status_reg0 = int_status_reg0;
    next_int_status_reg1 = int_status_reg1;
    if (wr_en && paddr == `LAATM_ADDR_INT_STATUS_REG0) begin
      next_int_status_reg0 = next_int_status_reg0 & ~pwdata[7:0];
    end
    if (wr_en && paddr == `LAATM_ADDR_INT_STATUS_REG1) begin
      next_int_status_reg1 = next_int_status_reg1 & ~pwdata[7:0];
    end
    next_int_status_reg0[`LAATM_B_LINE_SIGNAL_LOSS] = next_int_status_reg0[`LAATM_B_LINE_SIGNAL_LOSS] | edge_hit(
      status_reg0[`LAATM_B_LINE_SIGNAL_LOSS], prev_status_reg0[`LAATM_B_LINE_SIGNAL_LOSS], int_edge_sel_reg[`LAATM_B_LOS_IES]);
    next_int_status_reg0[`LAATM_B_SYSTEM_SIGNAL_LOSS] = next_int_status_reg0[`LAATM_B_SYSTEM_SIGNAL_LOSS] | edge_hit(
      status_reg0[`LAATM_B_SYSTEM_SIGNAL_LOSS], prev_status_reg0[`LAATM_B_SYSTEM_SIGNAL_LOSS], int_edge_sel_reg[`LAATM_B_LOS_IES]);
    next_int_status_reg0[`LAATM_B_TX_LINE_SIGNAL_LOSS] = next_int_status_reg0[`LAATM_B_TX_LINE_SIGNAL_LOSS] | edge_hit(
      status_reg0[`LAATM_B_TX_LINE_SIGNAL_LOSS], prev_status_reg0[`LAATM_B_TX_LINE_SIGNAL_LOSS], int_edge_sel_reg[`LAATM_B_TX_LOSS_EDGE_SEL]);
    next_int_status_reg1[`LAATM_B_RXAIS] = next_int_status_reg1[`LAATM_B_RXAIS] | edge_hit(
      status_reg1[`LAATM_B_RXAIS], prev_status_reg1[`LAATM_B_RXAIS], int_edge_sel_reg[`LAATM_B_AIS_EDGE_SEL]);
    next_int_status_reg1[`LAATM_B_TXAIS] = next_int_status_reg1[`LAATM_B_TXAIS] | edge_hit(
      status_reg1[`LAATM_B_TXAIS], prev_status_reg1[`LAATM_B_TXAIS], int_edge_sel_reg[`LAATM_B_AIS_EDGE_SEL]);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_status_reg0 <= `LAATM_RST_BYTE;
      int_status_reg1 <= `LAATM_RST_BYTE;
    end else begin
      int_status_reg0 <= next_int_status_reg0;
      int_status_reg1 <= next_int_status_reg1;
    end
  end

  // Shared interrupt, active low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_n <= 1'b1;
    end else begin
      int_n <= ~(|(int_status_reg0 & ~int_mask_reg0) | |(int_status_reg1 & ~int_mask_reg1));
    end
  end

  // Automatic AIS generation
  assign rx_ais_gen = (auto_ais_ctrl[`LAATM_B_RXA_LINE_SIGNAL_LOSS] & line_signal_loss) |
                      (auto_ais_ctrl[`LAATM_B_RXA_SYSTEM_SIGNAL_LOSS] & system_signal_loss);
  assign tx_ais_gen = (auto_ais_ctrl[`LAATM_B_TXA_LINE_SIGNAL_LOSS] & line_signal_loss) |
                      (auto_ais_ctrl[`LAATM_B_TXA_SYSTEM_SIGNAL_LOSS] & system_signal_loss);

  // Receive outputs; pattern first, then AIS, then normal data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_data_out <= 1'b0;
      rx_data_pos_out <= 1'b0;
      rx_data_neg_out <= 1'b0;
      rx_clock_out <= 1'b0;
    end else if (rx_pattern_on) begin
      rx_data_out <= rx_pattern_bit;
      rx_data_pos_out <= rx_pattern_bit;
      rx_data_neg_out <= 1'b0;
      rx_clock_out <= local_ref_clock;
    end else if (rx_ais_gen) begin
      rx_data_out <= 1'b1;
      rx_data_pos_out <= 1'b1;
      rx_data_neg_out <= 1'b1;
      rx_clock_out <= local_ref_clock;
    end else begin
      rx_data_out <= rx_data_in;
      rx_data_pos_out <= rx_data_pos_in;
      rx_data_neg_out <= rx_data_neg_in;
      rx_clock_out <= rx_clock_in;
    end
  end

  // Transmit line; AIS ones sent as alternating marks on the reference clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_line_tip <= 1'b0;
      tx_line_ring <= 1'b0;
      tx_line_oe_n <= 1'b1;
    end else begin
      tx_line_oe_n <= ~tx_config0[`LAATM_B_OE];
      if (tx_pattern_on) begin
        tx_line_tip <= tx_pattern_bit;
        tx_line_ring <= ~tx_pattern_bit;
      end else if (tx_ais_gen) begin
        tx_line_tip <= local_ref_clock;
        tx_line_ring <= ~local_ref_clock;
      end else begin
        tx_line_tip <= tx_data_pos_in;
        tx_line_ring <= tx_data_neg_in;
      end
    end
  end

  // Counter events and multifunction pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_loss_event <= 1'b0;
      rx_ais_event <= 1'b0;
      tx_ais_event <= 1'b0;
      tx_multifunc_pin <= 1'b0;
      rx_multifunc_pin <= 1'b0;
    end else begin
      tx_loss_event <= tx_line_signal_loss & ~status_reg0[`LAATM_B_TX_LINE_SIGNAL_LOSS];
      rx_ais_event <= ais_det[0] & ~status_reg1[`LAATM_B_RXAIS];
      tx_ais_event <= ais_det[1] & ~status_reg1[`LAATM_B_TXAIS];
      unique case (tx_mf_sel)
        2'h0: tx_multifunc_pin <= 1'b0;
        2'h1: tx_multifunc_pin <= tx_line_signal_loss;
        2'h2: tx_multifunc_pin <= ais_det[1];
        2'h3: tx_multifunc_pin <= system_signal_loss;
      endcase
      unique case (rx_mf_sel)
        2'h0: rx_multifunc_pin <= 1'b0;
        2'h1: rx_multifunc_pin <= line_signal_loss;
        2'h2: rx_multifunc_pin <= ais_det[0];
        2'h3: rx_multifunc_pin <= ais_det[1];
      endcase
    end
  end

endmodule

// ### core/laatm_pkg.sv
package laatm_pkg;
  typedef enum logic {
    LAATM_AIS_CLEAR,
    LAATM_AIS_SET
  } laatm_ais_state_t;
endpackage

// ### testbench/laatm_alarm_monitor.sv
`timescale 1ns/1ps
module laatm_alarm_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic line_signal_loss,
  input wire logic system_signal_loss,
  input wire logic tx_line_pulse,
  input wire logic tx_line_low,
  input wire logic local_ref_clock,
  input wire logic rx_data_in,
  input wire logic rx_pattern_on,
  input wire logic rx_pattern_bit,
  input wire logic [1:0] tx_mf_sel,
  input wire logic rx_data_out,
  input wire logic rx_clock_out,
  input wire logic tx_line_oe_n,
  input wire logic [1:0] tx_loss_amplitude_sel,
  input wire logic tx_multifunc_pin,
  input wire logic [1:0] rx_mf_sel,
  input wire logic rx_multifunc_pin,
  input wire logic tx_loss_event,
  input wire logic rx_ais_event,
  input wire logic tx_ais_event,
  input wire logic int_n
);
  logic [7:0] cfg;
  logic [3:0] aut;
  logic oe;
  logic [7:0] msk0;
  logic [7:0] msk1;
  logic rx_ais_on;
  logic quiet;
  logic wr;
  assign wr = psel && penable && pwrite;
  assign rx_ais_on = (aut[2] && line_signal_loss) || (aut[3] && system_signal_loss);
  assign quiet = !line_signal_loss && !system_signal_loss && !rx_pattern_on;
  // Shadow copies of the mask, loss, auto AIS and transmit config registers, taken from APB writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg <= 8'h00;
      aut <= 4'h0;
      oe <= 1'b1;
      msk0 <= 8'h00;
      msk1 <= 8'h00;
    end else if (wr) begin
      case (paddr)
        12'h014: msk0 <= pwdata[7:0];
        12'h018: msk1 <= pwdata[7:0];
        12'h01c: cfg <= pwdata[7:0];
        12'h020: aut <= pwdata[3:0];
        12'h024: oe <= pwdata[6];
        default: ;
      endcase
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ready_high_a: assert property (pready && !pslverr)
    else $error("APB slave stalled or flagged an error");
  amp_sel_a: assert property (tx_loss_amplitude_sel == cfg[3:2])
    else $error("amplitude select differs from config");
  oe_drive_a: assert property (!$past(rst) |-> tx_line_oe_n == !$past(oe))
    else $error("line enable does not follow config");
  loss_clear_a: assert property (tx_mf_sel == 2'h1 && tx_line_pulse && !tx_line_low
    |-> ##[2:5] !tx_multifunc_pin) else $error("transmit loss kept after a pulse");
  rx_ais_ones_a: assert property ((rx_ais_on && !rx_pattern_on)[*5] |=> rx_data_out)
    else $error("receive data not all ones in AIS");
  rx_ais_clk_a: assert property ((rx_ais_on && !rx_pattern_on)[*5]
    |=> rx_clock_out == $past(local_ref_clock)) else $error("receive clock not reference");
  pattern_first_a: assert property (rx_pattern_on[*2]
    |=> rx_data_out == $past(rx_pattern_bit)) else $error("pattern not on receive data");
  pass_thru_a: assert property (quiet[*5] |=> rx_data_out == $past(rx_data_in))
    else $error("receive data altered without loss");
  int_mask_a: assert property ((msk0[2:0] == 3'h7 && msk1[7:6] == 2'h3)[*4] |=> int_n)
    else $error("interrupt raised while masked");
  loss_event_a: assert property ($past(tx_mf_sel) == 2'h1
    && $past(tx_mf_sel, 2) == 2'h1 |-> tx_loss_event == $rose(tx_multifunc_pin))
    else $error("loss event not on loss rise");
  ais_event_a: assert property ($past(rx_mf_sel) == 2'h2
    && $past(tx_mf_sel) == 2'h2 && $past(rx_mf_sel, 2) == 2'h2 && $past(tx_mf_sel, 2) == 2'h2
    |-> rx_ais_event == $rose(rx_multifunc_pin) && tx_ais_event == $rose(tx_multifunc_pin))
    else $error("AIS event not on AIS rise");
endmodule

// ### testbench/laatm_bench.sv
`timescale 1ns/1ps
module laatm_bench;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fail = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, tx_line_pulse, tx_line_low, rx_bit_en, rx_bit, tx_bit_en, tx_bit;
  logic line_signal_loss = 1'b0, system_signal_loss = 1'b0, rx_pattern_on = 1'b0;
  logic tx_pattern_on = 1'b0, local_ref_clock = 1'b0, rx_clock_in = 1'b0, rx_data_in = 1'b0;
  logic rx_data_pos_in = 1'b0, rx_data_neg_in = 1'b0, tx_data_pos_in = 1'b0;
  logic tx_data_neg_in = 1'b0, rx_pattern_bit = 1'b0, tx_pattern_bit = 1'b0, pb, tb;
  logic [1:0] tx_mf_sel = 2'h1, rx_mf_sel = 2'h1, tx_loss_amplitude_sel;
  logic rx_data_out, rx_data_pos_out, rx_data_neg_out, rx_clock_out, tx_line_tip;
  logic tx_line_ring, tx_line_oe_n, tx_multifunc_pin, rx_multifunc_pin, tx_loss_event;
  logic rx_ais_event, tx_ais_event, int_n;
  int n_fail = 0, comparisons = 0, rx_gap = 100, tx_gap = 100, prev = 0, cur;
  int tab [3][4] = '{'{1, 1, 0, 100}, '{1, 0, 100, 300}, '{0, 1, 0, 500}};
  integer seed = 86550;
  laatm_monitor u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .line_signal_loss, .system_signal_loss, .tx_line_pulse, .tx_line_low, .rx_bit_en,
    .rx_bit, .tx_bit_en, .tx_bit, .local_ref_clock, .rx_clock_in, .rx_data_in, .rx_data_pos_in,
    .rx_data_neg_in, .tx_data_pos_in, .tx_data_neg_in, .rx_pattern_on, .tx_pattern_on,
    .rx_pattern_bit, .tx_pattern_bit, .tx_mf_sel, .rx_mf_sel, .rx_data_out, .rx_data_pos_out,
    .rx_data_neg_out, .rx_clock_out, .tx_line_tip, .tx_line_ring, .tx_line_oe_n,
    .tx_loss_amplitude_sel, .tx_multifunc_pin, .rx_multifunc_pin, .tx_loss_event,
    .rx_ais_event, .tx_ais_event, .int_n);
  laatm_line_model u_line (.clk, .rst, .tx_line_oe_n, .fail, .rx_gap, .tx_gap, .rx_bit_en,
    .rx_bit, .tx_bit_en, .tx_bit, .tx_line_pulse, .tx_line_low);
  always #5 clk = ~clk;
  always @(posedge clk) begin
    {local_ref_clock, rx_clock_in, rx_data_in, rx_data_pos_in, rx_data_neg_in, tx_data_pos_in,
      tx_data_neg_in, rx_pattern_bit, tx_pattern_bit} <= 9'($random(seed));
  end
  function automatic int ais_exp(input int e1, input int gap);
    int blk;
    blk = e1 ? 512 : 8192;
    return ((gap == 0 ? 0 : blk / gap) < (e1 ? 3 : 9)) ? 1 : 0;
  endfunction
  task automatic results;
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 50) begin
      n_fail++;
      results();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 12; i++) rd(12'(4 * i), i == 9 ? 32'h40 : 32'h0);
    wr(12'h000, 32'hff);
    wr(12'h02c, 32'hff);
    rd(12'h000, 32'h0);
    rd(12'h02c, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 2; i++) begin
      wr(12'h01c, 32'(i));
      wr(12'h010, 32'(i * 4));
      if (i == 0) begin
        fail <= 1'b1;
      end else begin
        wr(12'h024, 32'h0);
      end
      repeat (i ? 200 : 40) @(posedge clk);
      rd(12'h000, 32'h0);
      repeat (100) @(posedge clk);
      rd(12'h000, 32'h4);
      rd(12'h008, 32'h4);
      chk(int_n, 0);
      chk(tx_multifunc_pin, 1);
      wr(12'h014, 32'h7);
      wr(12'h018, 32'hc0);
      repeat (6) @(posedge clk);
      chk(int_n, 1);
      wr(12'h014, 32'h0);
      wr(12'h018, 32'h0);
      wr(12'h008, 32'h4);
      rd(12'h008, 32'h0);
      fail <= 1'b0;
      wr(12'h024, 32'h40);
      repeat (20) @(posedge clk);
      rd(12'h000, 32'h0);
      rd(12'h008, 32'(i * 4));
      wr(12'h008, 32'h4);
      $display("test transmit loss %0d done", i);
    end
    rx_mf_sel <= 2'h2;
    tx_mf_sel <= 2'h2;
    for (int i = 0; i < 3; i++) begin
      wr(12'h028, 32'(tab[i][0]));
      wr(12'h01c, 32'(tab[i][1] * 128));
      rx_gap <= tab[i][2];
      tx_gap <= tab[i][3];
      repeat (tab[i][0] ? 3100 : 49200) @(posedge clk);
      cur = ais_exp(tab[i][0], tab[i][2]) * 64 + ais_exp(tab[i][0], tab[i][3]) * 128;
      rd(12'h004, 32'(cur));
      chk({tx_multifunc_pin, rx_multifunc_pin}, cur >> 6);
      rd(12'h00c, 32'(cur & ~prev));
      wr(12'h00c, 32'hc0);
      prev = cur;
      $display("test ais %0d done", i);
    end
    for (int i = 0; i < 2; i++) begin
      wr(12'h020, i ? 32'ha : 32'h5);
      line_signal_loss <= (i == 0);
      system_signal_loss <= (i == 1);
      tx_mf_sel <= i ? 2'h3 : 2'h0;
      rx_mf_sel <= i ? 2'h3 : 2'h1;
      repeat (8) @(posedge clk);
      rd(12'h000, i ? 32'h2 : 32'h1);
      chk({rx_data_out, rx_data_pos_out, rx_data_neg_out}, 3'h7);
      chk(tx_line_tip ^ tx_line_ring, 1);
      chk({tx_multifunc_pin, rx_multifunc_pin}, i ? 2 : 1);
      rx_pattern_on <= 1'b1;
      tx_pattern_on <= 1'b1;
      repeat (3) @(posedge clk);
      pb = rx_pattern_bit;
      tb = tx_pattern_bit;
      @(posedge clk);
      chk(rx_data_out, pb);
      chk({tx_line_tip, tx_line_ring}, {tb, !tb});
      rx_pattern_on <= 1'b0;
      tx_pattern_on <= 1'b0;
      line_signal_loss <= 1'b0;
      system_signal_loss <= 1'b0;
      repeat (8) @(posedge clk);
      pb = rx_data_in;
      @(posedge clk);
      chk(rx_data_out, pb);
      $display("test auto ais %0d done", i);
    end
    results();
  end
endmodule
bind laatm_monitor laatm_alarm_chk u_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .line_signal_loss, .system_signal_loss, .tx_line_pulse,
  .tx_line_low, .local_ref_clock, .rx_data_in, .rx_pattern_on, .rx_pattern_bit, .tx_mf_sel,
  .rx_data_out, .rx_clock_out, .tx_line_oe_n, .tx_loss_amplitude_sel, .tx_multifunc_pin,
  .rx_mf_sel, .rx_multifunc_pin, .tx_loss_event, .rx_ais_event, .tx_ais_event, .int_n);

// ### testbench/laatm_line_model.sv
`timescale 1ns/1ps
module laatm_line_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_line_oe_n,
  input wire logic fail,
  input int rx_gap,
  input int tx_gap,
  output logic rx_bit_en,
  output logic rx_bit,
  output logic tx_bit_en,
  output logic tx_bit,
  output logic tx_line_pulse,
  output logic tx_line_low
);
  int cnt;
  logic live;
  // Only a driving, healthy channel puts pulses on the shared line
  assign live = !tx_line_oe_n && !fail;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      {rx_bit_en, rx_bit, tx_bit_en, tx_bit, tx_line_pulse, tx_line_low} <= 6'h00;
    end else begin
      rx_bit_en <= !rx_bit_en;
      tx_bit_en <= !rx_bit_en;
      tx_line_pulse <= !rx_bit_en && live;
      tx_line_low <= !live;
      if (!rx_bit_en) begin
        cnt <= cnt + 1;
        rx_bit <= !(rx_gap != 0 && cnt % rx_gap == 0);
        tx_bit <= !(tx_gap != 0 && cnt % tx_gap == 0);
      end
    end
  end
endmodule
